// *** bench/mcl_ctrl_model.sv ***
// Controller model that drives the two bridge control pins.
// Assumes the bench hands it the wanted levels before each edge.
`timescale 1ns/1ps
`default_nettype none
module mcl_ctrl_model (
   input  wire logic clk_i,
   input  wire logic a_i,
   input  wire logic b_i,
   output logic      pin_a_o,
   output logic      pin_b_o
);
   // pin writes
   // Pins move just after an edge, like a port write
   always_ff @(posedge clk_i) begin
      pin_a_o <= a_i;
      pin_b_o <= b_i;
   end
endmodule
`default_nettype wire

// *** bench/motor_current_limit_control_test.sv ***
// Self-checking bench of the current limit control block.
// Assumes the controller model on the pins and a Wishbone master task.
`timescale 1ns/1ps
`default_nettype none
module motor_current_limit_control_test;
   import mcl_pkg::*;
   localparam int unsigned HC = 12;
   logic        clk, rst_n, cyc, stb, we, ra, rb, tx, ti, pa, pb, ack, sns, fn, foe, ho;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat, q, v;
   mcl_gates_s  br;
   int          fails, n_checks, seed, t, cnt;

   mcl_ctrl_model u_mcl_ctrl_model (.clk_i(clk), .a_i(ra), .b_i(rb), .pin_a_o(pa), .pin_b_o(pb));
   mcl_top #(.HOLD_CYC(HC), .BLANK_CYC(2), .DEG_CYC(2)) u_mcl_top (
      .clk_i(clk), .reset_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .drive_input_a_i(pa), .drive_input_b_i(pb), .trip_ext_ref_i(tx), .trip_int_ref_i(ti),
      .bridge_o(br), .current_sense_out_o(sns), .fault_flag_n_o(fn),
      .fault_flag_oe_n_o(foe), .regulation_handoff_o(ho));

   // Clock at 10 MHz
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Hang guard, far above the expected run length
   always @(posedge clk) begin
      cnt++;
      if (cnt == 5000) begin
         fails++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Bridge gates expected from the truth tables
   function automatic logic [3:0] gx(input logic a, input logic b, input logic pwm);
      logic [15:0] pwm_t;
      pwm_t = 16'h5960;
      if (pwm) begin
         return pwm_t[{a, b} * 4 +: 4];
      end
      return !a ? 4'h5 : (b ? 4'h9 : 4'h6);
   endfunction

   // Classic single cycle; held until ack is seen
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (ack !== 1'b1 && t < 20);
      q = rdat;
      chk("ack", ack, 1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic ctl(input logic [10:0] c);
      wb(1'b1, CTRL_OFS, {21'h0, c});
   endtask

   task automatic pins(input logic a, input logic b);
      @(posedge clk);
      ra <= a;
      rb <= b;
   endtask

   task automatic trip(input logic e, input logic i);
      @(posedge clk);
      tx <= e;
      ti <= i;
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   // Bounded wait for a gate pattern, then compare
   task automatic exp_br(input logic [3:0] e, input int lim);
      @(negedge clk);
      t = 0;
      while (br !== e && t < lim) begin
         @(negedge clk);
         t++;
      end
      chk("bridge", br, e);
   endtask

   initial begin
      {rst_n, cyc, stb, we, ra, rb, tx, ti, adr, wdat} = '0;
      fails = 0;
      n_checks = 0;
      cnt = 0;
      seed = 32'h2c3e0969;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      wb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl", q, 32'h0);
      wb(1'b0, WIN_OFS, 32'h0);
      chk("win", q, 32'h2626);
      wb(1'b0, 8'h0c, 32'h0);
      chk("unmapped", q, 32'h0);
      exp_br(4'h5, 4);
      chk("fault", {fn, foe}, 2'b11);
      // Scheme codes 10b and 11b hand over, 00b keeps limiting
      for (int s = 2; s < 5; s++) begin
         ctl(11'(s & 3));
         wait_n(2);
         chk("handoff", ho, s < 4);
      end
      ctl(11'h640);
      exp_br(4'h9, 6);
      // Policy 00b with the trip held high never limits
      trip(1'b1, 1'b0);
      for (int k = 0; k < 24; k++) begin
         if (k % 12 == 0) begin
            ctl(k ? 11'h110 : 11'h010);
         end
         v = $random(seed);
         pins(v[0], v[1]);
         wait_n(3);
         chk("bridge", br, gx(v[0], v[1], k >= 12));
         chk("sense", sns, |(gx(v[0], v[1], k >= 12) & 4'h5));
      end
      trip(1'b0, 1'b0);
      ctl(11'h018);
      pins(1'b1, 1'b1);
      exp_br(4'h9, 6);
      trip(1'b1, 1'b0);
      exp_br(4'h5, 12);
      chk("sense", sns, 1);
      wait_n(HC + 2);
      chk("bridge", br, 4'h5);
      trip(1'b0, 1'b0);
      exp_br(4'h9, HC + 4);
      wait_n(6);
      trip(1'b1, 1'b0);
      trip(1'b0, 1'b0);
      wait_n(6);
      chk("bridge", br, 4'h9);
      trip(1'b1, 1'b0);
      exp_br(4'h5, 12);
      pins(1'b1, 1'b0);
      exp_br(4'h6, 4);
      trip(1'b0, 1'b0);
      // Cycle-by-cycle with report: hold until a pin edge
      ctl(11'h089);
      pins(1'b1, 1'b1);
      exp_br(4'h9, 8);
      trip(1'b1, 1'b0);
      exp_br(4'h5, 12);
      chk("fault", {fn, foe}, 2'b00);
      trip(1'b0, 1'b0);
      wait_n(HC + 4);
      chk("bridge", br, 4'h5);
      pins(1'b1, 1'b0);
      exp_br(4'h6, 4);
      chk("fault", {fn, foe}, 2'b11);
      // Internal reference ignores the external comparator
      ctl(11'h028);
      pins(1'b1, 1'b1);
      exp_br(4'h9, 6);
      trip(1'b1, 1'b0);
      wait_n(8);
      chk("bridge", br, 4'h9);
      trip(1'b0, 1'b1);
      exp_br(4'h5, 12);
      trip(1'b0, 1'b0);
      ctl(11'h004);
      exp_br(4'h9, HC + 4);
      trip(1'b1, 1'b0);
      exp_br(4'h5, 12);
      trip(1'b0, 1'b0);
      // Coast hides current; a short brake shows it again
      ctl(11'h100);
      pins(1'b0, 1'b0);
      exp_br(4'h0, 4);
      chk("sense", sns, 0);
      pins(1'b1, 1'b1);
      exp_br(4'h5, 4);
      chk("sense", sns, 1);
      pins(1'b0, 1'b0);
      // Stall watch: an empty startup window blocks limiting, a fresh one allows it
      wb(1'b1, WIN_OFS, 32'h0);
      ctl(11'h014);
      pins(1'b1, 1'b1);
      trip(1'b1, 1'b0);
      wait_n(8);
      chk("bridge", br, 4'h9);
      wb(1'b1, WIN_OFS, 32'h1);
      pins(1'b0, 1'b0);
      wait_n(3);
      pins(1'b1, 1'b1);
      exp_br(4'h9, 4);
      exp_br(4'h5, 12);
      trip(1'b0, 1'b0);
      // Mid-run reset: outputs idle at once, control register back to its reset value
      @(posedge clk);
      rst_n <= 1'b0;
      wait_n(1);
      chk("reset", {br, sns, fn, foe, ho}, 8'h06);
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      wb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl", q, 32'h0);
      give_verdict();
   end
endmodule
`default_nettype wire

// *** logic/mcl_hold_timer.sv ***
// Down counter that times one brake hold period.
// Assumes a synchronous start and stop from the owning state machine.
`timescale 1ns/1ps
`default_nettype none
module mcl_hold_timer
   import mcl_pkg::*;
#(
   parameter int unsigned CYC = BRAKE_HOLD_CYC
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic start_i,
   input  wire logic stop_i,
   output logic      done_o
);
   localparam int unsigned W = $clog2(CYC + 1);

   logic [W-1:0] cnt_q;

   generate
      if (CYC < 1) begin : g_bad
         $error("Hold time must be at least one cycle");
      end
   endgenerate

   // Load on start, clear on stop, else count down to zero
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= '0;
      end else if (start_i) begin
         cnt_q <= W'(CYC);
      end else if (stop_i) begin
         cnt_q <= '0;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   // Last cycle of the period, so the owner leaves on this edge
   assign done_o = (cnt_q == W'(1));

endmodule
`default_nettype wire

// *** logic/mcl_pkg.sv ***
// Constants, types and decode helpers for the motor current limit control block.
// Assumes one 10 MHz clock and a classic Wishbone register slave.
package mcl_pkg;

   // Clock
   localparam int unsigned CLK_PERIOD_NS = 100;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] WIN_OFS  = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;

   // Control register field positions
   localparam int unsigned CTRL_SCHEME_POS = 0;
   localparam int unsigned CTRL_POLICY_POS = 2;
   localparam int unsigned CTRL_WATCH_POS  = 4;
   localparam int unsigned CTRL_INTREF_POS = 5;
   localparam int unsigned CTRL_SRC_POS    = 6;
   localparam int unsigned CTRL_REPORT_POS = 7;
   localparam int unsigned CTRL_PWM_POS    = 8;
   localparam int unsigned CTRL_REGA_POS   = 9;
   localparam int unsigned CTRL_REGB_POS   = 10;
   localparam int unsigned CTRL_W          = 11;

   // Reset values
   localparam logic [10:0] CTRL_RST = 11'h000;
   localparam logic [15:0] WIN_RST  = 16'h2626;

   // Field encodings
   localparam logic [1:0] SCHEME_FIXED = 2'h0;
   localparam logic [1:0] SCHEME_CBC   = 2'h1;
   localparam logic [1:0] POLICY_OFF   = 2'h0;
   localparam logic [1:0] POLICY_WATCH = 2'h1;

   // Times in ns and their cycle counts (least times round up)
   localparam int unsigned BRAKE_HOLD_NS  = 20000;
   localparam int unsigned TRIP_BLANK_NS  = 1000;
   localparam int unsigned TRIP_FILTER_NS = 500;
   localparam int unsigned WIN_TICK_NS    = 102400;
   localparam int unsigned BRAKE_HOLD_CYC  = (BRAKE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TRIP_BLANK_CYC  = (TRIP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TRIP_FILTER_CYC = (TRIP_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WIN_TICK_CYC    = WIN_TICK_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {ST_FOLLOW, ST_OFFTIME, ST_CBC_HOLD} mcl_state_e;

   // Bridge gate commands, side a is OUT1 and side b is OUT2
   typedef struct packed {
      logic hs_a;
      logic ls_a;
      logic hs_b;
      logic ls_b;
   } mcl_gates_s;

   typedef struct packed {
      mcl_gates_s gates;
      logic       fault_low;
      logic       window;
      logic       trip_ok;
      logic [1:0] state;
   } mcl_status_s;

   localparam mcl_gates_s GATES_BRAKE = '{hs_a: 1'b0, ls_a: 1'b1, hs_b: 1'b0, ls_b: 1'b1};

   // Truth table of the two control modes
   function automatic mcl_gates_s mcl_cmd_gates(input logic a, input logic b, input logic pwm);
      mcl_gates_s g;
      g = '0;
      if (pwm) begin
         g.hs_a = a & ~b;
         g.ls_a = b;
         g.hs_b = b & ~a;
         g.ls_b = a;
      end else if (!a) begin
         g = GATES_BRAKE;
      end else begin
         g.hs_a = b;
         g.ls_b = b;
         g.hs_b = ~b;
         g.ls_a = ~b;
      end
      return g;
   endfunction

endpackage

// *** logic/mcl_top.sv ***
// Current limit control of a brushed DC H-bridge with a Wishbone register slave.
// Assumes pins and comparator levels synchronous to clk_i, and a classic
// single-cycle Wishbone master that holds each request until ack.
`timescale 1ns/1ps
`default_nettype none
module mcl_top
   import mcl_pkg::*;
#(
   parameter int unsigned HOLD_CYC  = BRAKE_HOLD_CYC,
   parameter int unsigned BLANK_CYC = TRIP_BLANK_CYC,
   parameter int unsigned DEG_CYC   = TRIP_FILTER_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        drive_input_a_i,
   input  wire logic        drive_input_b_i,
   input  wire logic        trip_ext_ref_i,
   input  wire logic        trip_int_ref_i,
   output mcl_gates_s       bridge_o,
   output logic             current_sense_out_o,
   output logic             fault_flag_n_o,
   output logic             fault_flag_oe_n_o,
   output logic             regulation_handoff_o
);

   generate
      if (HOLD_CYC < 1 || BLANK_CYC < 1 || DEG_CYC < 1) begin : g_bad
         $error("All durations must be at least one cycle");
      end
   endgenerate

   logic              rst_meta_q;
   logic              rst_n;
   logic [CTRL_W-1:0] ctrl_q;
   logic [15:0]       win_q;
   logic              req;
   logic              wr_en;
   logic [31:0]       rd_data;
   mcl_state_e        state_q;
   mcl_state_e        state_d;
   mcl_gates_s        cmd_gates;
   mcl_gates_s        gates_d;
   logic [1:0]        cmd;
   logic [1:0]        cmd_prev_q;
   logic [1:0]        cmd_chg;
   logic [1:0]        cmd_rise;
   logic              cmd_change;
   logic              cbc_release;
   logic              trip_raw;
   logic              trip_ok;
   logic              hold_done;
   logic              hold_start;
   logic              limit_en;
   logic              window_active;
   logic              drive_start;
   logic [9:0]        tick_q;
   logic [15:0]       win_cnt_q;
   logic              fault_d;
   mcl_status_s       status;

   // Field views of the control register
   logic [1:0] scheme;
   logic [1:0] policy;
   logic       stall_watch;
   logic       int_ref;
   logic       drive_source_select;
   logic       limit_flag_report;
   logic       pwm_mode;
   logic       register_drive_input_a;
   logic       register_drive_input_b;

   assign scheme                 = ctrl_q[CTRL_SCHEME_POS +: 2];
   assign policy                 = ctrl_q[CTRL_POLICY_POS +: 2];
   assign stall_watch            = ctrl_q[CTRL_WATCH_POS];
   assign int_ref                = ctrl_q[CTRL_INTREF_POS];
   assign drive_source_select    = ctrl_q[CTRL_SRC_POS];
   assign limit_flag_report      = ctrl_q[CTRL_REPORT_POS];
   assign pwm_mode               = ctrl_q[CTRL_PWM_POS];
   assign register_drive_input_a = ctrl_q[CTRL_REGA_POS];
   assign register_drive_input_b = ctrl_q[CTRL_REGB_POS];

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // Wishbone request; ack for one cycle, then drops even if stb stays
   assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_en = req && wb_we_i;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // Control register with byte lanes; bits above the field read zero
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RST;
      end else if (wr_en && wb_adr_i == CTRL_OFS) begin
         if (wb_sel_i[0]) begin
            ctrl_q[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            ctrl_q[CTRL_W-1:8] <= wb_dat_i[CTRL_W-1:8];
         end
      end
   end

   // Startup window length in ticks
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         win_q <= WIN_RST;
      end else if (wr_en && wb_adr_i == WIN_OFS) begin
         if (wb_sel_i[0]) begin
            win_q[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            win_q[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   // Read mux; unmapped addresses are acked with zero
   assign status = '{gates: bridge_o, fault_low: !fault_flag_n_o, window: window_active,
                     trip_ok: trip_ok, state: state_q};

   always_comb begin
      case (wb_adr_i)
         CTRL_OFS: rd_data = 32'(ctrl_q);
         WIN_OFS:  rd_data = 32'(win_q);
         STAT_OFS: rd_data = 32'(status);
         default:  rd_data = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req) begin
         wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_data;
      end
   end

   assign cmd = drive_source_select ? {register_drive_input_a, register_drive_input_b}
                                    : {drive_input_a_i, drive_input_b_i};

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cmd_prev_q <= 2'h0;
      end else begin
         cmd_prev_q <= cmd;
      end
   end

   // Per-input change and rising edge
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_edge
         assign cmd_chg[gi]  = cmd[gi] ^ cmd_prev_q[gi];
         assign cmd_rise[gi] = cmd[gi] & ~cmd_prev_q[gi];
      end
   endgenerate

   assign cmd_change = |cmd_chg;
   // pins release on any edge, register bits only on 0 to 1
   assign cbc_release = drive_source_select ? |cmd_rise : cmd_change;

   assign cmd_gates = mcl_cmd_gates(cmd[1], cmd[0], pwm_mode);

   assign trip_raw = int_ref ? trip_int_ref_i : trip_ext_ref_i;

   // Startup window restarts whenever the bridge begins to drive
   assign drive_start = (cmd_gates.hs_a || cmd_gates.hs_b) && !(bridge_o.hs_a || bridge_o.hs_b);

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tick_q <= 10'h000;
      end else if (drive_start || tick_q == 10'(WIN_TICK_CYC - 1)) begin
         tick_q <= 10'h000;
      end else begin
         tick_q <= tick_q + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         win_cnt_q <= WIN_RST;
      end else if (drive_start) begin
         win_cnt_q <= win_q;
      end else if (tick_q == 10'(WIN_TICK_CYC - 1) && win_cnt_q != 16'h0000) begin
         win_cnt_q <= win_cnt_q - 1'b1;
      end
   end

   assign window_active = (win_cnt_q != 16'h0000);

   // policy gate, upper schemes never limit
   always_comb begin
      if (scheme[1] || policy == POLICY_OFF) begin
         limit_en = 1'b0;
      end else if (policy == POLICY_WATCH) begin
         limit_en = stall_watch ? window_active : 1'b1;
      end else begin
         limit_en = 1'b1;
      end
   end

   mcl_trip_filter #(
      .BLANK_CYC (BLANK_CYC),
      .DEG_CYC   (DEG_CYC)
   ) u_filter (
      .clk_i         (clk_i),
      .rst_n_i       (rst_n),
      .blank_start_i (gates_d != bridge_o),
      .trip_i        (trip_raw),
      .trip_ok_o     (trip_ok)
   );

   // Limiting state machine
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_FOLLOW: begin
            // scheme choice, brake on a drive trip
            if (limit_en && trip_ok && (cmd_gates.hs_a || cmd_gates.hs_b)) begin
               if (scheme == SCHEME_FIXED) begin
                  state_d = ST_OFFTIME;
               end else if (scheme == SCHEME_CBC) begin
                  state_d = ST_CBC_HOLD;
               end
            end
         end
         ST_OFFTIME: begin
            if (cmd_change || !limit_en || scheme != SCHEME_FIXED) begin
               state_d = ST_FOLLOW;
            // end of period needs no input edge
            end else if (hold_done) begin
               state_d = trip_raw ? ST_OFFTIME : ST_FOLLOW;
            end
         end
         ST_CBC_HOLD: begin
            // hold until a release edge; limiting switched off ends it
            if (cbc_release || !limit_en || scheme != SCHEME_CBC) begin
               state_d = ST_FOLLOW;
            end
         end
         default: begin
            state_d = ST_FOLLOW;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_FOLLOW;
      end else begin
         state_q <= state_d;
      end
   end

   // a fresh full period on entry and on a repeat trip
   assign hold_start = (state_d == ST_OFFTIME) && (state_q != ST_OFFTIME || hold_done);

   mcl_hold_timer #(
      .CYC (HOLD_CYC)
   ) u_hold (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .start_i (hold_start),
      .stop_i  (state_d != ST_OFFTIME),
      .done_o  (hold_done)
   );

   assign gates_d = (state_d == ST_FOLLOW) ? cmd_gates : GATES_BRAKE;

   // fault flag while the cycle-by-cycle hold lasts
   assign fault_d = !(state_d == ST_CBC_HOLD && limit_flag_report);

   // Outputs register together so sense tracks the gates exactly
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         bridge_o             <= '0;
         current_sense_out_o  <= 1'b0;
         fault_flag_n_o       <= 1'b1;
         fault_flag_oe_n_o    <= 1'b1;
         regulation_handoff_o <= 1'b0;
      end else begin
         bridge_o             <= gates_d;
         // sense only through a conducting low side
         current_sense_out_o  <= gates_d.ls_a || gates_d.ls_b;
         fault_flag_n_o       <= fault_d;
         fault_flag_oe_n_o    <= fault_d;
         // upper schemes go to the regulation function
         regulation_handoff_o <= scheme[1];
      end
   end

   // Checks
   policy_off_a: assert property (
      @(posedge clk_i) disable iff (!rst_n)
      (policy == POLICY_OFF && state_q == ST_FOLLOW) |=> state_q == ST_FOLLOW)
      else $error("Limiting started with policy off");

   handoff_idle_a: assert property (
      @(posedge clk_i) disable iff (!rst_n)
      scheme[1] |=> state_q == ST_FOLLOW && regulation_handoff_o)
      else $error("Limiting ran under regulation handoff");

   watch_window_a: assert property (
      @(posedge clk_i) disable iff (!rst_n)
      (policy == POLICY_WATCH && stall_watch && !window_active && state_q == ST_FOLLOW)
         |=> state_q == ST_FOLLOW)
      else $error("Limiting outside startup window");

   offtime_brake_a: assert property (
      @(posedge clk_i) disable iff (!rst_n)
      state_q != ST_FOLLOW |-> bridge_o == GATES_BRAKE && current_sense_out_o)
      else $error("Bridge not braking during hold");

   offtime_end_a: assert property (
      @(posedge clk_i) disable iff (!rst_n)
      (state_q == ST_OFFTIME && hold_done && !trip_raw && !cmd_change)
         |=> state_q == ST_FOLLOW && bridge_o == $past(cmd_gates))
      else $error("Outputs not restored after off time");

   input_abort_a: assert property (
      @(posedge clk_i) disable iff (!rst_n)
      (state_q == ST_OFFTIME && cmd_change) |=> bridge_o == $past(cmd_gates))
      else $error("Input change did not end the hold");

   cbc_hold_a: assert property (
      @(posedge clk_i) disable iff (!rst_n)
      (state_q == ST_CBC_HOLD && !cbc_release && limit_en && scheme == SCHEME_CBC)
         |=> state_q == ST_CBC_HOLD)
      else $error("Cycle hold released without an edge");

   cbc_report_a: assert property (
      @(posedge clk_i) disable iff (!rst_n)
      (state_d == ST_CBC_HOLD && limit_flag_report) |=> !fault_flag_n_o && !fault_flag_oe_n_o)
      else $error("Fault flag not low during reported hold");

   coast_sense_a: assert property (
      @(posedge clk_i) disable iff (!rst_n)
      (bridge_o == '0) |-> !current_sense_out_o)
      else $error("Sense active while coasting");

   wb_ack_one_a: assert property (
      @(posedge clk_i) disable iff (!rst_n)
      wb_ack_o |=> !wb_ack_o)
      else $error("Ack held longer than one cycle");

endmodule
`default_nettype wire

// *** logic/mcl_trip_filter.sv ***
// Blanking and deglitch of the trip comparator.
// Assumes the comparator level is synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module mcl_trip_filter
   import mcl_pkg::*;
#(
   parameter int unsigned BLANK_CYC = TRIP_BLANK_CYC,
   parameter int unsigned DEG_CYC   = TRIP_FILTER_CYC
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic blank_start_i,
   input  wire logic trip_i,
   output logic      trip_ok_o
);
   localparam int unsigned BW = $clog2(BLANK_CYC + 1);
   localparam int unsigned DW = $clog2(DEG_CYC + 1);

   logic [BW-1:0] blank_q;
   logic [DW-1:0] deg_q;
   logic          quiet;

   generate
      if (BLANK_CYC < 1 || DEG_CYC < 1) begin : g_bad
         $error("Blank and filter times must be at least one cycle");
      end
   endgenerate

   assign quiet = !blank_start_i && (blank_q == '0);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         blank_q <= '0;
      end else if (blank_start_i) begin
         blank_q <= BW'(BLANK_CYC);
      end else if (blank_q != '0) begin
         blank_q <= blank_q - 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         deg_q <= '0;
      end else if (!quiet || !trip_i) begin
         deg_q <= '0;
      end else if (deg_q != DW'(DEG_CYC)) begin
         deg_q <= deg_q + 1'b1;
      end
   end

   // Filtered trip drops on the next clock edge after the raw level falls
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         trip_ok_o <= 1'b0;
      end else begin
         trip_ok_o <= quiet && trip_i && (32'(deg_q) + 1 >= DEG_CYC);
      end
   end

   blank_quiet_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      blank_start_i |=> !trip_ok_o)
      else $error("Trip accepted during blanking");

   deglitch_hold_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(trip_ok_o) |-> $past(trip_i) && $past(blank_q == '0))
      else $error("Trip accepted without a steady comparator");

endmodule
`default_nettype wire
